// File: verilog/nvc_pkg.sv
// Purpose: shared constants, types and helpers of the vectored interrupt controller
// Assumes: one clock, APB register access, 32 interrupt lines
// Notes: ranks are internal; 0 is most urgent, 7 means thread level
package nvc_pkg;
   // vector table and exception numbers
   localparam logic [31:0] VT_BASE = 32'h0000_0000;
   localparam logic [5:0] EXC_SP = 6'h00;
   localparam logic [5:0] EXC_RESET = 6'h01;
   localparam logic [5:0] EXC_IRQ0 = 6'h10;
   // sys slots: 0 nmi, 1 hard fault, 2 svc, 3 pendable_service_exception, 4 tick
   localparam int SYS_N = 5;
   localparam int SX_SVC = 2;
   localparam int SX_PENDABLE_SERVICE_EXCEPTION = 3;
   localparam int SX_TICK = 4;
   // ranks
   localparam logic [2:0] RANK_RESET = 3'h0;
   localparam logic [2:0] RANK_NMI = 3'h1;
   localparam logic [2:0] RANK_HARD = 3'h2;
   localparam logic [2:0] RANK_CFG0 = 3'h3;
   localparam logic [2:0] RANK_THREAD = 3'h7;
   localparam logic [1:0] PRIO_RESET = 2'h0;
   localparam int PRIO_LSB = 6;
   localparam int FIELD_W = 8;
   // implemented lines and lines that may wake the chip
   localparam logic [31:0] IRQ_IMPL = 32'h30FF_5F7F;
   localparam logic [31:0] IRQ_WAKE = 32'h100F_103F;
   // register byte offsets
   localparam logic [7:0] OFS_SETENA = 8'h00;
   localparam logic [7:0] OFS_CLRENA = 8'h04;
   localparam logic [7:0] OFS_SETPEND = 8'h08;
   localparam logic [7:0] OFS_CLRPEND = 8'h0C;
   localparam logic [7:0] OFS_PRIO0 = 8'h10;
   localparam logic [7:0] OFS_SYSPRI = 8'h30;
   localparam logic [7:0] OFS_SYSPEND = 8'h34;
   localparam logic [7:0] OFS_STATUS = 8'h38;
   localparam int STAT_RANK_LSB = 8;
   localparam int STAT_RUN_BIT = 16;

   typedef enum logic [1:0] {BOOT_SP, BOOT_VEC, RUNNING} nvc_boot_t;

   typedef struct packed {
      logic valid;
      logic initial_main_stack_pointer;
      logic [5:0] vec;
      logic [31:0] addr;
   } nvc_core_req_t;

   typedef struct packed {
      logic ack;
      logic ret;
      logic [5:0] ret_vec;
   } nvc_core_resp_t;

   typedef struct packed {
      nvc_boot_t boot;
      logic [31:0] enable;
      logic [31:0] pend;
      logic [31:0] active;
      logic [31:0][1:0] prio;
      logic [4:2][1:0] sys_prio;
      logic [SYS_N-1:0] sys_pend;
      logic [SYS_N-1:0] sys_act;
      nvc_core_req_t req;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic wake;
   } nvc_state_t;

   localparam nvc_state_t ST_RESET = '0;

   function automatic logic [2:0] nvc_cfg_rank(logic [1:0] p);
      return {1'b0, p} + RANK_CFG0;
   endfunction

   function automatic logic [2:0] nvc_sys_rank(int k, logic [4:2][1:0] sp);
      if (k == 0)
         return RANK_NMI;
      else if (k == 1)
         return RANK_HARD;
      else
         return nvc_cfg_rank(sp[k]);
   endfunction

   function automatic logic [5:0] nvc_sys_vec(int k);
      logic [5:0] v;
      v = 6'h00;
      case (k)
         0: v = 6'h02;
         1: v = 6'h03;
         2: v = 6'h0B;
         3: v = 6'h0E;
         default: v = 6'h0F;
      endcase
      return v;
   endfunction

   function automatic logic [31:0] nvc_vec_addr(logic [5:0] v);
      return VT_BASE + {24'h00_0000, v, 2'b00};
   endfunction
endpackage

// File: verilog/nvc_arbiter.sv
// Purpose: picks the most urgent candidate exception
// Assumes: candidates already gated by enable and pending
// Notes: ties go to the lower exception number
`timescale 1ns/10ps
module nvc_arbiter (
   input wire logic [31:0] cand,
   input wire logic [31:0][1:0] prio,
   input wire logic [nvc_pkg::SYS_N-1:0] sys_cand,
   input wire logic [4:2][1:0] sys_prio,
   output logic win_valid,
   output logic [5:0] win_vec,
   output logic [2:0] win_rank
);
   // scan downward so equal ranks settle on the lowest number
   always_comb
   begin
      win_valid = 1'b0;
      win_vec = 6'h00;
      win_rank = nvc_pkg::RANK_THREAD;
      for (int i = 31; i >= 0; i--)
      begin
         if (cand[i] && nvc_pkg::nvc_cfg_rank(prio[i]) <= win_rank)
         begin
            win_valid = 1'b1;
            win_rank = nvc_pkg::nvc_cfg_rank(prio[i]);
            win_vec = nvc_pkg::EXC_IRQ0 + 6'(i);
         end
      end
      for (int k = nvc_pkg::SYS_N - 1; k >= 0; k--)
      begin
         if (sys_cand[k] && nvc_pkg::nvc_sys_rank(k, sys_prio) <= win_rank)
         begin
            win_valid = 1'b1;
            win_rank = nvc_pkg::nvc_sys_rank(k, sys_prio);
            win_vec = nvc_pkg::nvc_sys_vec(k);
         end
      end
   end
endmodule

// File: verilog/nvc_controller.sv
// Purpose: nested vectored interrupt controller with APB register access
// Assumes: sources and core signals are on pclk; core acks the presented vector
// Notes: one wait state on every APB access
// Contract
// - every configurable source has a level 0..3, 0 most urgent
// - all configurable levels read 0 after reset
// - reset, nmi, hard fault fixed above level 0; svc, pendable_service_exception, tick configurable
// - handler entry is the word at base zero plus exception number times four
// - word zero gives the initial main stack pointer, fetched first after reset
// - set and clear enable registers, write one acts, reads show enables
// - set and clear pending registers, write one acts, reads show pending
// - disabled lines still go pending but never activate
// - an active line stays active until reset or exception return
// - clearing pending never touches active state
// - each level sits in an 8-bit field, four fields per word
// - line 0 brown-out, line 1 watchdog; both wake the chip
// - lines 2 and 3 dedicated pin interrupts; both wake the chip
// - port groups on lines 4, 5, 16, 17; all wake the chip
// - line 6 pulse modulator, lines 20-23 captures; none wake
// - line 28 power-down wake request wakes; line 29 converter does not
// - only a strictly more urgent request preempts the running handler
// - requests are re-chosen at handler exit and during entry
`timescale 1ns/10ps
module nvc_controller (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic brownout_irq,
   input wire logic watchdog_irq,
   input wire logic ext_pin_irq_a,
   input wire logic ext_pin_irq_b,
   input wire logic port_group_a_irq,
   input wire logic port_group_b_irq,
   input wire logic port_group_c_irq,
   input wire logic port_group_d_irq,
   input wire logic pulse_mod_irq,
   input wire logic timer_a_irq,
   input wire logic timer_b_irq,
   input wire logic timer_c_irq,
   input wire logic timer_d_irq,
   input wire logic serial_port_irq,
   input wire logic sync_serial_irq,
   input wire logic two_wire_a_irq,
   input wire logic two_wire_b_irq,
   input wire logic capture_a_irq,
   input wire logic capture_b_irq,
   input wire logic capture_c_irq,
   input wire logic capture_d_irq,
   input wire logic powerdown_wake_irq,
   input wire logic converter_irq,
   input wire logic nmi_req,
   input wire logic hard_fault_req,
   input wire logic supervisor_call_exception,
   input wire logic system_tick_exception,
   input wire nvc_pkg::nvc_core_resp_t core_resp,
   output nvc_pkg::nvc_core_req_t core_req,
   output logic wake_req
);
   nvc_pkg::nvc_state_t s_ff;
   nvc_pkg::nvc_state_t nxt_s;
   logic [31:0] src;
   logic [31:0] hw_set;
   logic win_valid;
   logic [5:0] win_vec;
   logic [2:0] win_rank;
   logic [nvc_pkg::SYS_N-1:0] sys_hw;

   // address decode shared by read and write paths
   function automatic logic is_mapped(logic [7:0] a);
      return (a[1:0] == 2'b00) && (a <= nvc_pkg::OFS_STATUS);
   endfunction

   // byte address of the priority word holding line i
   function automatic logic [7:0] prio_addr(int i);
      return nvc_pkg::OFS_PRIO0 + 8'(4 * (i / 4));
   endfunction

   // lowest bit of the level in byte slot n of a word
   function automatic int fld_lsb(int n);
      return n * nvc_pkg::FIELD_W + nvc_pkg::PRIO_LSB;
   endfunction

   // one-hot line of an exception number
   function automatic logic [31:0] line_hits(logic [5:0] v);
      logic [31:0] h;
      h = 32'h0000_0000;
      for (int i = 0; i < 32; i++)
         h[i] = (v == nvc_pkg::EXC_IRQ0 + 6'(i));
      return h;
   endfunction

   // one-hot system slot of an exception number
   function automatic logic [nvc_pkg::SYS_N-1:0] sys_hits(logic [5:0] v);
      logic [nvc_pkg::SYS_N-1:0] h;
      h = '0;
      for (int k = 0; k < nvc_pkg::SYS_N; k++)
         h[k] = (v == nvc_pkg::nvc_sys_vec(k));
      return h;
   endfunction

   // rank of the most urgent active exception
   function automatic logic [2:0] run_rank(nvc_pkg::nvc_state_t st);
      logic [2:0] r;
      r = nvc_pkg::RANK_THREAD;
      if (st.boot != nvc_pkg::RUNNING)
         r = nvc_pkg::RANK_RESET;
      for (int i = 0; i < 32; i++)
      begin
         if (st.active[i] && nvc_pkg::nvc_cfg_rank(st.prio[i]) < r)
            r = nvc_pkg::nvc_cfg_rank(st.prio[i]);
      end
      for (int k = 0; k < nvc_pkg::SYS_N; k++)
      begin
         if (st.sys_act[k] && nvc_pkg::nvc_sys_rank(k, st.sys_prio) < r)
            r = nvc_pkg::nvc_sys_rank(k, st.sys_prio);
      end
      return r;
   endfunction

   // register read data
   function automatic logic [31:0] rd_word(logic [7:0] a, nvc_pkg::nvc_state_t st);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (a == nvc_pkg::OFS_SETENA || a == nvc_pkg::OFS_CLRENA)
         d = st.enable;
      else if (a == nvc_pkg::OFS_SETPEND || a == nvc_pkg::OFS_CLRPEND)
         d = st.pend;
      else if (a == nvc_pkg::OFS_SYSPRI)
      begin
         for (int k = nvc_pkg::SX_SVC; k <= nvc_pkg::SX_TICK; k++)
            d[fld_lsb(k - nvc_pkg::SX_SVC) +: 2] = st.sys_prio[k];
      end
      else if (a == nvc_pkg::OFS_SYSPEND)
         d[nvc_pkg::SYS_N-1:0] = st.sys_pend;
      else if (a == nvc_pkg::OFS_STATUS)
      begin
         d[nvc_pkg::SYS_N-1:0] = st.sys_act;
         d[nvc_pkg::STAT_RANK_LSB +: 3] = run_rank(st);
         d[nvc_pkg::STAT_RUN_BIT] = (st.boot == nvc_pkg::RUNNING);
      end
      else
      begin
         for (int i = 0; i < 32; i++)
         begin
            if (a == prio_addr(i))
               d[fld_lsb(i % 4) +: 2] = st.prio[i];
         end
      end
      return d;
   endfunction

   // fixed source placement on the interrupt lines
   always_comb
   begin
      src = 32'h0000_0000;
      src[0] = brownout_irq;
      src[1] = watchdog_irq;
      src[2] = ext_pin_irq_a;
      src[3] = ext_pin_irq_b;
      src[4] = port_group_a_irq;
      src[5] = port_group_b_irq;
      src[16] = port_group_c_irq;
      src[17] = port_group_d_irq;
      src[6] = pulse_mod_irq;
      src[20] = capture_a_irq;
      src[21] = capture_b_irq;
      src[22] = capture_c_irq;
      src[23] = capture_d_irq;
      src[28] = powerdown_wake_irq;
      src[29] = converter_irq;
      src[8] = timer_a_irq;
      src[9] = timer_b_irq;
      src[10] = timer_c_irq;
      src[11] = timer_d_irq;
      src[12] = serial_port_irq;
      src[14] = sync_serial_irq;
      src[18] = two_wire_a_irq;
      src[19] = two_wire_b_irq;
   end

   // reserved lines never reach pending
   assign hw_set = src & nvc_pkg::IRQ_IMPL;
   assign sys_hw = {system_tick_exception, 1'b0, supervisor_call_exception, hard_fault_req, nmi_req};

   // winner among enabled pending sources
   nvc_arbiter u_arb (
      .cand(s_ff.pend & s_ff.enable & ~s_ff.active),
      .prio(s_ff.prio),
      .sys_cand(s_ff.sys_pend & ~s_ff.sys_act),
      .sys_prio(s_ff.sys_prio),
      .win_valid(win_valid),
      .win_vec(win_vec),
      .win_rank(win_rank)
   );

   // next state
   always_comb
   begin
      logic wr;
      logic take;
      logic [31:0] en_set;
      logic [31:0] en_clr;
      logic [31:0] pd_set;
      logic [31:0] pd_clr;
      logic [31:0] act_set;
      logic [31:0] act_clr;
      logic [nvc_pkg::SYS_N-1:0] sp_set;
      logic [nvc_pkg::SYS_N-1:0] sa_set;
      logic [nvc_pkg::SYS_N-1:0] sa_clr;
      wr = 1'b0;
      take = 1'b0;
      en_set = 32'h0000_0000;
      en_clr = 32'h0000_0000;
      pd_set = 32'h0000_0000;
      pd_clr = 32'h0000_0000;
      act_set = 32'h0000_0000;
      act_clr = 32'h0000_0000;
      sp_set = '0;
      sa_set = '0;
      sa_clr = '0;
      nxt_s = s_ff;

      // apb: one wait state, write lands on the completing edge
      nxt_s.pready = 1'b0;
      nxt_s.pslverr = 1'b0;
      if (psel && penable && !s_ff.pready)
      begin
         nxt_s.pready = 1'b1;
         nxt_s.pslverr = !is_mapped(paddr);
         nxt_s.prdata = is_mapped(paddr) ? rd_word(paddr, s_ff) : 32'h0000_0000;
      end
      wr = psel && penable && pwrite && s_ff.pready && is_mapped(paddr);
      if (wr && paddr == nvc_pkg::OFS_SETENA)
         en_set = pwdata;
      if (wr && paddr == nvc_pkg::OFS_CLRENA)
         en_clr = pwdata;
      if (wr && paddr == nvc_pkg::OFS_SETPEND)
         pd_set = pwdata;
      if (wr && paddr == nvc_pkg::OFS_CLRPEND)
         pd_clr = pwdata;
      if (wr && paddr == nvc_pkg::OFS_SYSPEND)
         sp_set = pwdata[nvc_pkg::SYS_N-1:0] & 5'h1C;
      // priority fields
      for (int i = 0; i < 32; i++)
      begin
         if (wr && paddr == prio_addr(i))
            nxt_s.prio[i] = pwdata[fld_lsb(i % 4) +: 2];
      end
      for (int k = nvc_pkg::SX_SVC; k <= nvc_pkg::SX_TICK; k++)
      begin
         if (wr && paddr == nvc_pkg::OFS_SYSPRI)
            nxt_s.sys_prio[k] = pwdata[fld_lsb(k - nvc_pkg::SX_SVC) +: 2];
      end

      // core taking the presented vector
      take = core_resp.ack && s_ff.req.valid;
      if (take && s_ff.boot == nvc_pkg::RUNNING)
      begin
         act_set = line_hits(s_ff.req.vec);
         sa_set = sys_hits(s_ff.req.vec);
      end
      // exception return retires only that handler
      if (core_resp.ret)
      begin
         act_clr = line_hits(core_resp.ret_vec);
         sa_clr = sys_hits(core_resp.ret_vec);
      end

      // enable: setting wins over clearing
      nxt_s.enable = ((s_ff.enable & ~en_clr) | en_set) & nvc_pkg::IRQ_IMPL;
      // pending: sources and set win over clear and activation
      nxt_s.pend = ((s_ff.pend & ~pd_clr & ~act_set) | hw_set | pd_set) & nvc_pkg::IRQ_IMPL;
      // active is untouched by pending clears or enable changes
      nxt_s.active = (s_ff.active & ~act_clr) | act_set;
      nxt_s.sys_pend = (s_ff.sys_pend & ~sa_set) | sys_hw | sp_set;
      nxt_s.sys_act = (s_ff.sys_act & ~sa_clr) | sa_set;

      // vector presentation
      unique case (s_ff.boot)
         nvc_pkg::BOOT_SP:
         begin
            nxt_s.req.valid = 1'b1;
            nxt_s.req.initial_main_stack_pointer = 1'b1;
            nxt_s.req.vec = nvc_pkg::EXC_SP;
            nxt_s.req.addr = nvc_pkg::VT_BASE;
            if (take)
            begin
               nxt_s.boot = nvc_pkg::BOOT_VEC;
               nxt_s.req.initial_main_stack_pointer = 1'b0;
               nxt_s.req.vec = nvc_pkg::EXC_RESET;
               nxt_s.req.addr = nvc_pkg::nvc_vec_addr(nvc_pkg::EXC_RESET);
            end
         end
         nvc_pkg::BOOT_VEC:
         begin
            if (take)
            begin
               nxt_s.boot = nvc_pkg::RUNNING;
               nxt_s.req.valid = 1'b0;
            end
         end
         nvc_pkg::RUNNING:
         begin
            // re-chosen every cycle: late arrival and tail chaining
            nxt_s.req.valid = !take && win_valid && (win_rank < run_rank(s_ff));
            nxt_s.req.initial_main_stack_pointer = 1'b0;
            nxt_s.req.vec = win_vec;
            nxt_s.req.addr = nvc_pkg::nvc_vec_addr(win_vec);
         end
         // unused state code: restart from the stack pointer word
         default:
         begin
            nxt_s.boot = nvc_pkg::BOOT_SP;
            nxt_s.req = '0;
         end
      endcase

      // wake request from enabled wake-capable sources
      nxt_s.wake = |(hw_set & s_ff.enable & nvc_pkg::IRQ_WAKE);
   end

   // state register; all levels start at zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_ff <= nvc_pkg::ST_RESET;
      else
         s_ff <= nxt_s;
   end

   // outputs straight from the state register
   assign prdata = s_ff.prdata;
   assign pready = s_ff.pready;
   assign pslverr = s_ff.pslverr;
   assign core_req = s_ff.req;
   assign wake_req = s_ff.wake;
endmodule

// File: test/nvc_chk.sv
// Purpose: port-level assertions for the vectored interrupt controller
// Assumes: one clock domain, apb access with one wait state
// Notes: bound to the controller at the foot of this file
`timescale 1ns/10ps
module nvc_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire nvc_pkg::nvc_core_resp_t core_resp,
   input wire nvc_pkg::nvc_core_req_t core_req
);
   localparam logic [31:0] LINES = 32'h30FF_5F7F;
   logic done;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // completed apb transfer
   assign done = psel && penable && pready;
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   apb_wait_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   bad_addr_a: assert property (done && (paddr[1:0] != 2'b00 || paddr > 8'h38)
      |-> pslverr && (pwrite || prdata == '0))
      else $error("unmapped access not refused");
   good_addr_a: assert property (done && paddr[1:0] == 2'b00 && paddr <= 8'h38 |-> !pslverr)
      else $error("mapped access refused");
   impl_read_a: assert property (done && !pwrite && paddr < 8'h10 |-> (prdata & ~LINES) == '0)
      else $error("reserved line bit reads one");
   prio_field_a: assert property (done && !pwrite && paddr inside {[8'h10:8'h2C]}
      |-> (prdata & 32'h3F3F_3F3F) == '0)
      else $error("priority word has stray bits");
   boot_sp_a: assert property ($rose(presetn)
      |=> core_req.valid && core_req.initial_main_stack_pointer && core_req.addr == '0)
      else $error("stack pointer word not fetched first");
   boot_next_a: assert property (core_req.valid && core_resp.ack && core_req.initial_main_stack_pointer
      |=> core_req.valid && core_req.vec == 6'h01)
      else $error("reset vector not presented after stack pointer word");
   vec_addr_a: assert property (core_req.valid |-> core_req.addr == {24'h00_0000, core_req.vec, 2'b00})
      else $error("vector address not number times four");
   no_rsvd_a: assert property (core_req.valid |-> !(core_req.vec inside {[6'h04:6'h0A], 6'h0C, 6'h0D,
      6'h17, 6'h1D, 6'h1F, [6'h28:6'h2B], 6'h2E, 6'h2F}))
      else $error("reserved vector presented");
   ack_drop_a: assert property (core_req.valid && core_resp.ack && !core_req.initial_main_stack_pointer
      |=> !core_req.valid)
      else $error("request kept after ack");
endmodule
bind nvc_controller nvc_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_resp(core_resp), .core_req(core_req));

// File: test/nvc_core_model.sv
// Purpose: processor side that takes presented vectors and returns from handlers
// Assumes: acks after ack_wait cycles of a valid request
// Notes: returns only when the bench asks for them
`timescale 1ns/10ps
module nvc_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire nvc_pkg::nvc_core_req_t core_req,
   input wire logic [3:0] ack_wait,
   input wire logic ret_go,
   input wire logic [5:0] ret_sel,
   output nvc_pkg::nvc_core_resp_t core_resp,
   output logic [5:0] last_vec,
   output logic [31:0] last_addr,
   output int takes
);
   logic [3:0] wait_ff;
   // ack after a delay, log every vector taken
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         core_resp <= '0;
         wait_ff <= '0;
         last_vec <= '0;
         last_addr <= '0;
         takes <= 0;
      end
      else
      begin
         core_resp.ret <= ret_go;
         core_resp.ret_vec <= ret_sel;
         core_resp.ack <= core_req.valid && !core_resp.ack && wait_ff >= ack_wait;
         wait_ff <= (core_req.valid && !core_resp.ack && wait_ff < ack_wait) ? wait_ff + 4'h1 : 4'h0;
         if (core_resp.ack && core_req.valid)
         begin
            last_vec <= core_req.vec;
            last_addr <= core_req.addr;
            takes <= takes + 1;
         end
      end
   end
endmodule

// File: test/nested_vectored_irq_controller_test.sv
// Purpose: self-checking bench for the vectored interrupt controller
// Assumes: apb master here, core model on the vector side
// Notes: sources are packed by line number in src
`timescale 1ns/10ps
module nested_vectored_irq_controller_test;
   localparam logic [31:0] IMPL = 32'h30FF_5F7F;
   localparam logic [31:0] WAKE = 32'h100F_103F;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wake_req, ret_go;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, src, last_addr;
   logic [4:0] sysr;
   logic [3:0] slow;
   logic [5:0] ret_sel, last_vec;
   nvc_pkg::nvc_core_resp_t core_resp;
   nvc_pkg::nvc_core_req_t core_req;
   int takes, nt, err_count, compares;
   nvc_controller dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .brownout_irq(src[0]), .watchdog_irq(src[1]), .ext_pin_irq_a(src[2]), .ext_pin_irq_b(src[3]),
      .port_group_a_irq(src[4]), .port_group_b_irq(src[5]), .pulse_mod_irq(src[6]), .timer_a_irq(src[8]),
      .timer_b_irq(src[9]), .timer_c_irq(src[10]), .timer_d_irq(src[11]), .serial_port_irq(src[12]),
      .sync_serial_irq(src[14]), .port_group_c_irq(src[16]), .port_group_d_irq(src[17]),
      .two_wire_a_irq(src[18]), .two_wire_b_irq(src[19]), .capture_a_irq(src[20]), .capture_b_irq(src[21]),
      .capture_c_irq(src[22]), .capture_d_irq(src[23]), .powerdown_wake_irq(src[28]), .converter_irq(src[29]),
      .nmi_req(sysr[0]), .hard_fault_req(sysr[1]), .supervisor_call_exception(sysr[2]),
      .system_tick_exception(sysr[4]), .core_resp(core_resp), .core_req(core_req), .wake_req(wake_req));
   nvc_core_model core (.pclk(pclk), .presetn(presetn), .core_req(core_req), .ack_wait(slow), .ret_go(ret_go),
      .ret_sel(ret_sel), .core_resp(core_resp), .last_vec(last_vec), .last_addr(last_addr), .takes(takes));
   // verdict and end of run
   task automatic end_sim();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic bad();
      err_count++;
      $display("unexpected at %0t: wait ran out", $time);
      end_sim();
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x)
      begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      if (i >= 20)
         bad();
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // wait for the core to take the next vector
   task automatic take(input logic [5:0] v);
      int i;
      nt++;
      for (i = 0; takes != nt && i < 60; i++)
         @(posedge pclk);
      if (i >= 60)
         bad();
      #1;
      chk({26'h0, last_vec}, {26'h0, v});
      chk(last_addr, {24'h00_0000, v, 2'b00});
   endtask
   task automatic no_take();
      repeat (12) @(posedge pclk);
      chk(32'(takes), 32'(nt));
   endtask
   task automatic ret(input logic [5:0] v);
      @(posedge pclk);
      ret_go <= 1'b1;
      ret_sel <= v;
      @(posedge pclk);
      ret_go <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   task automatic pulse(input int n);
      @(posedge pclk);
      src[n] <= 1'b1;
      @(posedge pclk);
      src[n] <= 1'b0;
   endtask
   task automatic s_regs();
      logic [31:0] r;
      logic e;
      for (int a = 16; a < 48; a += 4)
      begin
         apb(1'b0, 8'(a), '0, r, e);
         chk(r, '0);
      end
      apb(1'b1, 8'h10, '1, r, e);
      apb(1'b0, 8'h10, '0, r, e);
      chk(r, 32'hC0C0_C0C0);
      apb(1'b1, 8'h10, '0, r, e);
      apb(1'b0, 8'h3C, '0, r, e);
      chk({e, r[30:0]}, 32'h8000_0000);
      apb(1'b0, 8'h38, '0, r, e);
      chk({31'h0, r[16]}, 32'h1);
   endtask
   task automatic s_en_pend();
      logic [31:0] r;
      logic e;
      apb(1'b1, 8'h00, '1, r, e);
      apb(1'b0, 8'h04, '0, r, e);
      chk(r, IMPL);
      apb(1'b1, 8'h04, 32'h1, r, e);
      apb(1'b0, 8'h00, '0, r, e);
      chk(r, IMPL & ~32'h1);
      apb(1'b1, 8'h04, '1, r, e);
      apb(1'b1, 8'h08, '1, r, e);
      apb(1'b0, 8'h0C, '0, r, e);
      chk(r, IMPL);
      no_take();
      apb(1'b1, 8'h00, 32'h100, r, e);
      take(6'h18);
      ret(6'h18);
      apb(1'b1, 8'h04, '1, r, e);
      apb(1'b1, 8'h0C, '1, r, e);
      apb(1'b0, 8'h08, '0, r, e);
      chk(r, '0);
   endtask
   // every implemented line alone: vector, address and wake request
   task automatic s_map();
      logic [31:0] r;
      logic e;
      for (int n = 0; n < 32; n++)
      begin
         if (IMPL[n])
         begin
            apb(1'b1, 8'h00, 32'h1 << n, r, e);
            pulse(n);
            #1;
            chk({31'h0, wake_req}, {31'h0, WAKE[n]});
            take(6'(16 + n));
            ret(6'(16 + n));
            apb(1'b1, 8'h04, 32'h1 << n, r, e);
         end
      end
   endtask
   task automatic s_sys();
      logic [31:0] r;
      logic e;
      logic [5:0] v[5] = '{6'h02, 6'h03, 6'h0B, 6'h0E, 6'h0F};
      for (int k = 0; k < 5; k++)
      begin
         if (k == 3)
            apb(1'b1, 8'h34, 32'h8, r, e);
         else
         begin
            @(posedge pclk);
            sysr[k] <= 1'b1;
            @(posedge pclk);
            sysr[k] <= 1'b0;
         end
         take(v[k]);
         ret(v[k]);
      end
   endtask
   // preemption, masking of active line, chaining at exit
   task automatic s_nest();
      logic [31:0] r;
      logic e;
      slow <= 4'h3;
      apb(1'b1, 8'h10, 32'h0000_8040, r, e);
      apb(1'b1, 8'h00, 32'hF, r, e);
      pulse(1);
      take(6'h11);
      apb(1'b1, 8'h04, 32'h2, r, e);
      apb(1'b1, 8'h0C, 32'h2, r, e);
      apb(1'b0, 8'h38, '0, r, e);
      chk({29'h0, r[10:8]}, 32'h5);
      pulse(2);
      take(6'h12);
      pulse(0);
      pulse(3);
      no_take();
      ret(6'h12);
      take(6'h13);
      ret(6'h13);
      take(6'h10);
      ret(6'h10);
      ret(6'h11);
      slow <= 4'h0;
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      src = '0;
      sysr = '0;
      slow = '0;
      ret_go = 1'b0;
      ret_sel = '0;
      err_count = 0;
      compares = 0;
      nt = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      take(6'h00);
      take(6'h01);
      s_regs();
      s_en_pend();
      s_map();
      s_sys();
      s_nest();
      end_sim();
   end
endmodule
